// ==== verilog/dmt_timers.sv ====
// Two counter/timers with shared prescaler and clock select register,
// reached over the 8-bit special-function-register port.
// Assumes interrupt enables, gate polarity and vector acknowledges come
// from logic on the same clock; count, gate and clock pins are asynchronous.
`timescale 1ns/1ns
module dmt_timers (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire dmt_pkg::dmt_sfr_req_s sfr_req_in,
    output logic [7:0] sfr_rdata_out,
    input wire logic timer_a_count_pin_in,
    input wire logic timer_b_count_pin_in,
    input wire logic ext_irq_a_input_in,
    input wire logic ext_irq_b_input_in,
    input wire logic ext_irq_a_polarity_in,
    input wire logic ext_irq_b_polarity_in,
    input wire logic timer_a_irq_enable_in,
    input wire logic timer_b_irq_enable_in,
    input wire logic timer_a_vector_ack_in,
    input wire logic timer_b_vector_ack_in,
    input wire logic ext_clock_in,
    input wire logic third_timer_ext_clock_option_in,
    output logic timer_a_irq_req_out,
    output logic timer_b_irq_req_out,
    output logic timer_b_overflow_out,
    output logic third_timer_low_tick_out,
    output logic third_timer_high_tick_out
);

    // Clock select fields; bits 7 and 2 have no storage at all
    logic third_timer_high_clock_sel_r;
    logic third_timer_low_clock_sel_r;
    logic timer_b_clock_sel_r;
    logic timer_a_clock_sel_r;
    logic [1:0] prescale_select_r;
    logic [7:0] timer_control_reg_r;
    logic [7:0] timer_mode_reg_r;
    logic [7:0] timer_a_low_byte_r;
    logic [7:0] timer_a_high_byte_r;
    logic [7:0] timer_b_low_byte_r;
    logic [7:0] timer_b_high_byte_r;

    // Pin synchronisers: {count a, count b, gate a, gate b}
    logic [3:0] pin_s1_r;
    logic [3:0] pin_s2_r;
    logic [3:0] pin_s3_r;

    wire presc_tick;
    wire div12_tick;
    wire ext8_tick;

    dmt_prescaler u_prescaler (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .ext_clock_in(ext_clock_in),
        .prescale_select_in(prescale_select_r),
        .presc_tick_out(presc_tick),
        .div12_tick_out(div12_tick),
        .ext8_tick_out(ext8_tick)
    );

    // One increment of a timer in modes 0 to 2
    function automatic dmt_pkg::dmt_step_s step(input logic [1:0] mode,
                                                 input logic [7:0] hi,
                                                 input logic [7:0] lo);
        dmt_pkg::dmt_step_s s;
        logic [16:0] w;
        s.hi = hi;
        s.lo = lo;
        s.ovf = 1'b0;
        w = 17'h0_0000;
        case (mode)
            dmt_pkg::MODE_13BIT: begin
                w = 17'({hi, lo[4:0]}) + 17'h0_0001;
                s.hi = w[12:5];
                s.lo = {lo[7:5], w[4:0]};
                s.ovf = w[13];
            end
            dmt_pkg::MODE_16BIT: begin
                w = 17'({hi, lo}) + 17'h0_0001;
                s.hi = w[15:8];
                s.lo = w[7:0];
                s.ovf = w[16];
            end
            dmt_pkg::MODE_8BIT_RELOAD: begin
                if (lo == 8'hFF) begin
                    s.lo = hi;
                    s.ovf = 1'b1;
                end else begin
                    s.lo = lo + 8'h01;
                end
            end
            default: begin
                s.ovf = 1'b0;
            end
        endcase
        return s;
    endfunction

    // Register bus decode
    wire wr_clk_sel = sfr_req_in.wr &
        (sfr_req_in.addr == dmt_pkg::TIMER_CLOCK_SELECT_ADDR);
    wire wr_control = sfr_req_in.wr &
        (sfr_req_in.addr == dmt_pkg::TIMER_CONTROL_REG_ADDR);
    wire wr_mode = sfr_req_in.wr &
        (sfr_req_in.addr == dmt_pkg::TIMER_MODE_REG_ADDR);
    wire wr_tla = sfr_req_in.wr &
        (sfr_req_in.addr == dmt_pkg::TIMER_A_LOW_ADDR);
    wire wr_tha = sfr_req_in.wr &
        (sfr_req_in.addr == dmt_pkg::TIMER_A_HIGH_ADDR);
    wire wr_tlb = sfr_req_in.wr &
        (sfr_req_in.addr == dmt_pkg::TIMER_B_LOW_ADDR);
    wire wr_thb = sfr_req_in.wr &
        (sfr_req_in.addr == dmt_pkg::TIMER_B_HIGH_ADDR);

    // Control fields
    wire [1:0] mode_a = timer_mode_reg_r[dmt_pkg::TMR_A_MODE_LSB +: 2];
    wire [1:0] mode_b = timer_mode_reg_r[dmt_pkg::TMR_B_MODE_LSB +: 2];
    wire gate_a = timer_mode_reg_r[dmt_pkg::TMR_A_GATE_BIT];
    wire gate_b = timer_mode_reg_r[dmt_pkg::TMR_B_GATE_BIT];
    wire csel_a = timer_mode_reg_r[dmt_pkg::TMR_A_CSEL_BIT];
    wire csel_b = timer_mode_reg_r[dmt_pkg::TMR_B_CSEL_BIT];
    wire run_a_bit = timer_control_reg_r[dmt_pkg::TCR_A_RUN_BIT];
    wire run_b_bit = timer_control_reg_r[dmt_pkg::TCR_B_RUN_BIT];
    wire flag_a = timer_control_reg_r[dmt_pkg::TCR_A_FLAG_BIT];
    wire flag_b = timer_control_reg_r[dmt_pkg::TCR_B_FLAG_BIT];

    // Synchronised pin views, read only from the second stage onward
    wire fall_a = pin_s3_r[3] & ~pin_s2_r[3];
    wire fall_b = pin_s3_r[2] & ~pin_s2_r[2];
    wire gate_in_a = pin_s2_r[1] == ext_irq_a_polarity_in;
    wire gate_in_b = pin_s2_r[0] == ext_irq_b_polarity_in;

    wire split_a = mode_a == dmt_pkg::MODE_SPLIT;

    // Timer A (low byte in split mode)
    wire run_a = run_a_bit & (~gate_a | gate_in_a);
    wire clk_a = timer_a_clock_sel_r | presc_tick;
    wire tick_a = csel_a ? fall_a : clk_a;
    wire inc_a = run_a & tick_a;
    wire dmt_pkg::dmt_step_s step_a = step(mode_a, timer_a_high_byte_r,
                                            timer_a_low_byte_r);
    wire [8:0] split_lo = 9'(timer_a_low_byte_r) + 9'h001;
    wire [8:0] split_hi = 9'(timer_a_high_byte_r) + 9'h001;
    wire inc_ah = split_a & run_b_bit & clk_a;
    wire ovf_a = inc_a & (split_a ? split_lo[8] : step_a.ovf);

    // Timer B
    wire b_active = mode_b != dmt_pkg::MODE_SPLIT;
    wire run_b = split_a ? b_active :
        (run_b_bit & (~gate_b | gate_in_b));
    wire clk_b = timer_b_clock_sel_r | presc_tick;
    wire tick_b = (csel_b & ~split_a) ? fall_b : clk_b;
    wire inc_b = run_b & tick_b & b_active;
    wire dmt_pkg::dmt_step_s step_b = step(mode_b, timer_b_high_byte_r,
                                            timer_b_low_byte_r);
    wire ovf_b = inc_b & step_b.ovf;

    // Flag sources
    wire set_flag_a = ovf_a;
    wire set_flag_b = split_a ? (inc_ah & split_hi[8]) : ovf_b;

    // Next values; a register write beats a count in the same cycle
    logic [7:0] control_base;
    logic [7:0] timer_control_reg_nxt;
    logic [7:0] timer_a_low_byte_nxt;
    logic [7:0] timer_a_high_byte_nxt;
    logic [7:0] timer_b_low_byte_nxt;
    logic [7:0] timer_b_high_byte_nxt;
    logic [7:0] rdata_nxt;

    always_comb begin
        control_base = wr_control ? sfr_req_in.wdata : timer_control_reg_r;
        timer_control_reg_nxt = control_base;
        // Hardware set wins over software or vector clear
        if (set_flag_a) begin
            timer_control_reg_nxt[dmt_pkg::TCR_A_FLAG_BIT] = 1'b1;
        end else if (timer_a_vector_ack_in) begin
            timer_control_reg_nxt[dmt_pkg::TCR_A_FLAG_BIT] = 1'b0;
        end
        if (set_flag_b) begin
            timer_control_reg_nxt[dmt_pkg::TCR_B_FLAG_BIT] = 1'b1;
        end else if (timer_b_vector_ack_in) begin
            timer_control_reg_nxt[dmt_pkg::TCR_B_FLAG_BIT] = 1'b0;
        end
    end

    // Run bits never touch the count registers
    always_comb begin
        timer_a_low_byte_nxt = timer_a_low_byte_r;
        timer_a_high_byte_nxt = timer_a_high_byte_r;
        if (wr_tla) begin
            timer_a_low_byte_nxt = sfr_req_in.wdata;
        end else if (inc_a) begin
            timer_a_low_byte_nxt = split_a ? split_lo[7:0] : step_a.lo;
        end
        if (wr_tha) begin
            timer_a_high_byte_nxt = sfr_req_in.wdata;
        end else if (inc_ah) begin
            timer_a_high_byte_nxt = split_hi[7:0];
        end else if (inc_a & ~split_a) begin
            timer_a_high_byte_nxt = step_a.hi;
        end
    end

    always_comb begin
        timer_b_low_byte_nxt = timer_b_low_byte_r;
        timer_b_high_byte_nxt = timer_b_high_byte_r;
        if (wr_tlb) begin
            timer_b_low_byte_nxt = sfr_req_in.wdata;
        end else if (inc_b) begin
            timer_b_low_byte_nxt = step_b.lo;
        end
        if (wr_thb) begin
            timer_b_high_byte_nxt = sfr_req_in.wdata;
        end else if (inc_b) begin
            timer_b_high_byte_nxt = step_b.hi;
        end
    end

    always_comb begin
        case (sfr_req_in.addr)
            dmt_pkg::TIMER_CLOCK_SELECT_ADDR:
                rdata_nxt = {1'b0, third_timer_high_clock_sel_r,
                             third_timer_low_clock_sel_r, timer_b_clock_sel_r,
                             timer_a_clock_sel_r, 1'b0, prescale_select_r};
            dmt_pkg::TIMER_CONTROL_REG_ADDR: rdata_nxt = timer_control_reg_r;
            dmt_pkg::TIMER_MODE_REG_ADDR: rdata_nxt = timer_mode_reg_r;
            dmt_pkg::TIMER_A_LOW_ADDR: rdata_nxt = timer_a_low_byte_r;
            dmt_pkg::TIMER_A_HIGH_ADDR: rdata_nxt = timer_a_high_byte_r;
            dmt_pkg::TIMER_B_LOW_ADDR: rdata_nxt = timer_b_low_byte_r;
            dmt_pkg::TIMER_B_HIGH_ADDR: rdata_nxt = timer_b_high_byte_r;
            default: rdata_nxt = 8'h00;
        endcase
    end

    // Third timer clock choices; the option clock is sysclk/12 or ext/8
    wire third_opt_tick = third_timer_ext_clock_option_in ? ext8_tick :
        div12_tick;

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            pin_s1_r <= 4'h0;
            pin_s2_r <= 4'h0;
            pin_s3_r <= 4'h0;
        end else begin
            pin_s1_r <= {timer_a_count_pin_in, timer_b_count_pin_in,
                         ext_irq_a_input_in, ext_irq_b_input_in};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            third_timer_high_clock_sel_r <= 1'b0;
            third_timer_low_clock_sel_r <= 1'b0;
            timer_b_clock_sel_r <= 1'b0;
            timer_a_clock_sel_r <= 1'b0;
            prescale_select_r <= 2'h0;
        end else if (wr_clk_sel) begin
            third_timer_high_clock_sel_r <=
                sfr_req_in.wdata[dmt_pkg::CKS_THIRD_HIGH_BIT];
            third_timer_low_clock_sel_r <=
                sfr_req_in.wdata[dmt_pkg::CKS_THIRD_LOW_BIT];
            timer_b_clock_sel_r <= sfr_req_in.wdata[dmt_pkg::CKS_TIMER_B_BIT];
            timer_a_clock_sel_r <= sfr_req_in.wdata[dmt_pkg::CKS_TIMER_A_BIT];
            prescale_select_r <=
                sfr_req_in.wdata[dmt_pkg::CKS_PRESCALE_LSB +: 2];
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            timer_control_reg_r <= dmt_pkg::TIMER_CONTROL_RESET;
            timer_mode_reg_r <= dmt_pkg::TIMER_MODE_RESET;
            timer_a_low_byte_r <= dmt_pkg::COUNT_BYTE_RESET;
            timer_a_high_byte_r <= dmt_pkg::COUNT_BYTE_RESET;
            timer_b_low_byte_r <= dmt_pkg::COUNT_BYTE_RESET;
            timer_b_high_byte_r <= dmt_pkg::COUNT_BYTE_RESET;
        end else begin
            timer_control_reg_r <= timer_control_reg_nxt;
            timer_mode_reg_r <= wr_mode ? sfr_req_in.wdata : timer_mode_reg_r;
            timer_a_low_byte_r <= timer_a_low_byte_nxt;
            timer_a_high_byte_r <= timer_a_high_byte_nxt;
            timer_b_low_byte_r <= timer_b_low_byte_nxt;
            timer_b_high_byte_r <= timer_b_high_byte_nxt;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            sfr_rdata_out <= 8'h00;
            timer_a_irq_req_out <= 1'b0;
            timer_b_irq_req_out <= 1'b0;
            timer_b_overflow_out <= 1'b0;
            third_timer_low_tick_out <= 1'b0;
            third_timer_high_tick_out <= 1'b0;
        end else begin
            sfr_rdata_out <= sfr_req_in.rd ? rdata_nxt : sfr_rdata_out;
            timer_a_irq_req_out <= flag_a & timer_a_irq_enable_in;
            timer_b_irq_req_out <= flag_b & timer_b_irq_enable_in;
            timer_b_overflow_out <= ovf_b;
            third_timer_low_tick_out <=
                third_timer_low_clock_sel_r | third_opt_tick;
            third_timer_high_tick_out <=
                third_timer_high_clock_sel_r | third_opt_tick;
        end
    end

    // Checks on the counting core

    AST_WRAP13_FLAG: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        (mode_a == dmt_pkg::MODE_13BIT && inc_a && !wr_tla && !wr_tha &&
         timer_a_high_byte_r == 8'hFF && timer_a_low_byte_r[4:0] == 5'h1F)
        |=> (flag_a && timer_a_high_byte_r == 8'h00 &&
             timer_a_low_byte_r[4:0] == 5'h00))
        else $error("13-bit wrap did not clear count and set flag");

    AST_RELOAD: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        (mode_a == dmt_pkg::MODE_8BIT_RELOAD && inc_a && !wr_tla &&
         !wr_tha && timer_a_low_byte_r == 8'hFF)
        |=> (timer_a_low_byte_r == $past(timer_a_high_byte_r) &&
             $stable(timer_a_high_byte_r) && flag_a))
        else $error("Auto-reload did not copy high byte");

    AST_HOLD_WHEN_STOPPED: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        (!run_a_bit && !split_a && !wr_tla && !wr_tha)
        |=> ($stable(timer_a_low_byte_r) && $stable(timer_a_high_byte_r)))
        else $error("Stopped timer A changed its count");

    AST_RUN_KEEPS_COUNT: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        (wr_control && !run_a_bit && sfr_req_in.wdata[dmt_pkg::TCR_A_RUN_BIT]
         && !wr_tla) |=> $stable(timer_a_low_byte_r))
        else $error("Starting timer A altered its count");

    AST_SPLIT_B_FLAG: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        (split_a && run_b_bit && clk_a && !wr_tha &&
         timer_a_high_byte_r == 8'hFF)
        |=> (flag_b && timer_a_high_byte_r == 8'h00))
        else $error("Split high byte overflow missed timer B flag");

    AST_SPLIT_B_STOP: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        (split_a && mode_b == dmt_pkg::MODE_SPLIT && !wr_tlb && !wr_thb)
        |=> ($stable(timer_b_low_byte_r) && $stable(timer_b_high_byte_r)))
        else $error("Timer B counted in mode 3 while A is split");

    AST_IRQ_GATING: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        timer_a_irq_req_out == $past(flag_a && timer_a_irq_enable_in, 1))
        else $error("Timer A request does not follow flag and enable");

    AST_SET_BEATS_CLEAR: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        (set_flag_b && (timer_b_vector_ack_in || wr_control)) |=> flag_b)
        else $error("Flag clear swallowed a same-cycle overflow");

    AST_FALL_COUNT: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        (mode_a == dmt_pkg::MODE_16BIT && csel_a && run_a && !fall_a &&
         !wr_tla && !wr_tha) |=> $stable(timer_a_low_byte_r))
        else $error("Counter mode advanced without a pin falling edge");

endmodule // dmt_timers

// ==== verilog/dmt_pkg.sv ====
// Package for the dual mode counter/timers: register map, field positions,
// mode codes and the register-bus carrier.
// Assumes an 8-bit special-function-register bus on the system clock.
package dmt_pkg;

    // Register addresses
    localparam logic [7:0] TIMER_CONTROL_REG_ADDR = 8'h88;
    localparam logic [7:0] TIMER_MODE_REG_ADDR = 8'h89;
    localparam logic [7:0] TIMER_A_LOW_ADDR = 8'h8A;
    localparam logic [7:0] TIMER_B_LOW_ADDR = 8'h8B;
    localparam logic [7:0] TIMER_A_HIGH_ADDR = 8'h8C;
    localparam logic [7:0] TIMER_B_HIGH_ADDR = 8'h8D;
    localparam logic [7:0] TIMER_CLOCK_SELECT_ADDR = 8'h8E;

    // Reset values
    localparam logic [7:0] TIMER_CLOCK_SELECT_RESET = 8'h00;
    localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;
    localparam logic [7:0] TIMER_MODE_RESET = 8'h00;
    localparam logic [7:0] COUNT_BYTE_RESET = 8'h00;

    // Clock select register fields
    localparam int CKS_THIRD_HIGH_BIT = 6;
    localparam int CKS_THIRD_LOW_BIT = 5;
    localparam int CKS_TIMER_B_BIT = 4;
    localparam int CKS_TIMER_A_BIT = 3;
    localparam int CKS_PRESCALE_LSB = 0;

    // Timer control register fields
    localparam int TCR_B_FLAG_BIT = 7;
    localparam int TCR_B_RUN_BIT = 6;
    localparam int TCR_A_FLAG_BIT = 5;
    localparam int TCR_A_RUN_BIT = 4;

    // Timer mode register fields
    localparam int TMR_B_GATE_BIT = 7;
    localparam int TMR_B_CSEL_BIT = 6;
    localparam int TMR_B_MODE_LSB = 4;
    localparam int TMR_A_GATE_BIT = 3;
    localparam int TMR_A_CSEL_BIT = 2;
    localparam int TMR_A_MODE_LSB = 0;

    // Mode codes
    localparam logic [1:0] MODE_13BIT = 2'h0;
    localparam logic [1:0] MODE_16BIT = 2'h1;
    localparam logic [1:0] MODE_8BIT_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;

    // Prescale select codes
    localparam logic [1:0] PRESCALE_DIV12 = 2'h0;
    localparam logic [1:0] PRESCALE_DIV4 = 2'h1;
    localparam logic [1:0] PRESCALE_DIV48 = 2'h2;
    localparam logic [1:0] PRESCALE_EXT8 = 2'h3;

    // Prescaler ratios
    localparam int DIV_SHORT = 4;
    localparam int DIV_MID = 12;
    localparam int DIV_LONG = 48;
    localparam int EXT_DIV = 8;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } dmt_sfr_req_s;

    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
        logic ovf;
    } dmt_step_s;

endpackage

// ==== verilog/dmt_prescaler.sv ====
// Shared prescaler: system clock divided by 4, 12 and 48, and the external
// clock divided by 8, each as a one-cycle tick on the system clock.
// Assumes the external clock is slower than a quarter of the system clock.
`timescale 1ns/1ns
module dmt_prescaler (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic ext_clock_in,
    input wire logic [1:0] prescale_select_in,
    output logic presc_tick_out,
    output logic div12_tick_out,
    output logic ext8_tick_out
);

    logic [5:0] div_cnt_r;
    logic [2:0] ext_cnt_r;
    logic ext_s1_r;
    logic ext_s2_r;
    logic ext_s3_r;
    wire ext_rise;
    wire tick4;
    wire tick12;
    wire tick48;
    wire ext8;
    logic sel_tick;

    // True on the last count of a period that divides the long period
    function automatic logic period_end(input logic [5:0] c, input int p);
        return ((int'(c) + 1) % p) == 0;
    endfunction

    assign tick4 = period_end(div_cnt_r, dmt_pkg::DIV_SHORT);
    assign tick12 = period_end(div_cnt_r, dmt_pkg::DIV_MID);
    assign tick48 = period_end(div_cnt_r, dmt_pkg::DIV_LONG);
    assign ext_rise = ext_s2_r & ~ext_s3_r;
    assign ext8 = ext_rise & (ext_cnt_r == 3'(dmt_pkg::EXT_DIV - 1));

    always_comb begin
        case (prescale_select_in)
            dmt_pkg::PRESCALE_DIV12: sel_tick = tick12;
            dmt_pkg::PRESCALE_DIV4: sel_tick = tick4;
            dmt_pkg::PRESCALE_DIV48: sel_tick = tick48;
            default: sel_tick = ext8;
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            div_cnt_r <= 6'h00;
            ext_cnt_r <= 3'h0;
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
            presc_tick_out <= 1'b0;
            div12_tick_out <= 1'b0;
            ext8_tick_out <= 1'b0;
        end else begin
            div_cnt_r <= tick48 ? 6'h00 : div_cnt_r + 6'h01;
            ext_s1_r <= ext_clock_in;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
            if (ext_rise) begin
                ext_cnt_r <= ext_cnt_r + 3'h1;
            end
            presc_tick_out <= sel_tick;
            div12_tick_out <= tick12;
            ext8_tick_out <= ext8;
        end
    end

endmodule // dmt_prescaler

// ==== sim/dmt_pin_model.sv ====
// Count pin source for the counter/timers.
// Assumes start_in pulses for one cycle with pulses_in set.
`timescale 1ns/1ns
module dmt_pin_model (
    input wire logic clock_in,
    input wire logic [7:0] pulses_in,
    input wire logic start_in,
    output logic pin_out
);
    logic [7:0] left_r;
    logic [1:0] phase_r;
    always_ff @(posedge clock_in) begin
        if (start_in) begin
            left_r <= pulses_in;
            phase_r <= 2'h0;
        end else if (left_r != 8'h00) begin
            phase_r <= phase_r + 2'h1;
            if (phase_r == 2'h3) left_r <= left_r - 8'h01;
        end
    end
    // Two cycles high, two low; idles high
    assign pin_out = (left_r == 8'h00) | ~phase_r[1];
endmodule // dmt_pin_model

// ==== sim/dual_mode_counter_timers_test.sv ====
// Bench for the counter/timers: register tasks and scenarios.
// Assumes the pin model drives both count pins.
`timescale 1ns/1ns
module dual_mode_counter_timers_test;
    logic clk = 0, rst = 1, gate = 0, ien = 1, ack = 0, ext = 0, go = 1;
    logic pin, irq_a, irq_b, ovf_b, t3l, t3h;
    logic [7:0] rdata;
    dmt_pkg::dmt_sfr_req_s req = '0;
    int n_errors = 0, check_count = 0;
    int n_ovf = 0;
    initial forever #5 clk = ~clk;
    // Offset so the external clock never moves on a rising edge
    initial #2 forever #35 ext = ~ext;
    // Overflow pulse stands one cycle; counted where it is settled
    always @(negedge clk) if (ovf_b === 1'b1) n_ovf++;
    dmt_pin_model pins (.clock_in(clk), .pulses_in(8'h05), .start_in(go),
        .pin_out(pin));
    dmt_timers DUT (.clock_in(clk), .sys_rst_in(rst), .sfr_req_in(req),
        .sfr_rdata_out(rdata), .timer_a_count_pin_in(pin),
        .timer_b_count_pin_in(pin), .ext_irq_a_input_in(gate),
        .ext_irq_b_input_in(gate), .ext_irq_a_polarity_in(1'b1),
        .ext_irq_b_polarity_in(1'b1), .timer_a_irq_enable_in(ien),
        .timer_b_irq_enable_in(ien), .timer_a_vector_ack_in(ack),
        .timer_b_vector_ack_in(ack), .ext_clock_in(ext),
        .third_timer_ext_clock_option_in(1'b0),
        .timer_a_irq_req_out(irq_a), .timer_b_irq_req_out(irq_b),
        .timer_b_overflow_out(ovf_b), .third_timer_low_tick_out(t3l),
        .third_timer_high_tick_out(t3h));
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    // Idle cycle after each access keeps one assignment per time step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = '{a, 1'b1, 1'b0, d};
        @(negedge clk) req = '0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        req = '{a, 1'b0, 1'b1, 8'h00};
        @(negedge clk) req = '0;
        @(negedge clk) cmp8(rdata, exp);
    endtask
    task automatic report_and_stop;
        $display("mismatches %0d of %0d checks", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #100000;
        n_errors++;
        report_and_stop;
    end
    initial begin
        cyc(4);
        rst = 0;
        go = 0;
        rd(8'h8E, 8'h00);
        rd(8'h88, 8'h00);
        wr(8'h8E, 8'hFF);
        rd(8'h8E, 8'h7B);
        cmp8({7'h0, t3l}, 8'h01);
        cmp8({7'h0, t3h}, 8'h01);
        $display("test clock_select done");
        wr(8'h89, 8'h09);
        wr(8'h8A, 8'h55);
        wr(8'h88, 8'h10);
        cyc(20);
        rd(8'h8A, 8'h55);
        wr(8'h89, 8'h0D);
        gate = 1;
        go = 1;
        @(negedge clk) go = 0;
        cyc(30);
        rd(8'h8A, 8'h5A);
        $display("test gate_and_pin done");
        wr(8'h88, 8'h00);
        wr(8'h89, 8'h01);
        wr(8'h8C, 8'hFF);
        wr(8'h8A, 8'hF0);
        wr(8'h88, 8'h10);
        cyc(30);
        // Flags are read while running, so no write can fake them
        rd(8'h88, 8'h30);
        wr(8'h88, 8'h20);
        rd(8'h8C, 8'h00);
        rd(8'h8A, 8'h12);
        cmp8({7'h0, irq_a}, 8'h01);
        ack = 1;
        @(negedge clk) ack = 0;
        cyc(2);
        rd(8'h88, 8'h00);
        cmp8({7'h0, irq_a}, 8'h00);
        $display("test overflow done");
        ien = 0;
        wr(8'h89, 8'h20);
        wr(8'h8D, 8'hA0);
        wr(8'h8B, 8'hFE);
        wr(8'h88, 8'h40);
        // Lands on the reload edge: the overflow must beat the clear
        wr(8'h88, 8'h40);
        cyc(20);
        rd(8'h88, 8'hC0);
        wr(8'h88, 8'h80);
        rd(8'h8D, 8'hA0);
        rd(8'h8B, 8'hB8);
        cmp8({7'h0, irq_b}, 8'h00);
        cmp8(8'(n_ovf), 8'h01);
        $display("test reload done");
        wr(8'h89, 8'h33);
        wr(8'h88, 8'h40);
        wr(8'h8D, 8'hFF);
        wr(8'h8B, 8'hFF);
        cyc(4);
        rd(8'h8B, 8'hFF);
        wr(8'h89, 8'h03);
        rd(8'h88, 8'h40);
        cmp8(8'(n_ovf), 8'h02);
        wr(8'h8A, 8'h33);
        wr(8'h8C, 8'hF0);
        cyc(30);
        rd(8'h88, 8'hC0);
        rd(8'h8A, 8'h33);
        $display("test split done");
        wr(8'h88, 8'h00);
        wr(8'h8E, 8'h00);
        wr(8'h89, 8'h00);
        wr(8'h8C, 8'hFF);
        wr(8'h8A, 8'h1A);
        wr(8'h88, 8'h10);
        // 96 running edges hold exactly eight divide-by-12 ticks
        cyc(92);
        rd(8'h88, 8'h30);
        wr(8'h88, 8'h00);
        rd(8'h8C, 8'h00);
        rd(8'h8A, 8'h02);
        $display("test prescale done");
        report_and_stop;
    end
endmodule // dual_mode_counter_timers_test
